// ===== hdl/tmo_pkg.sv
package tmo_pkg;
    // -------------------------------------------------------------
    // register map (byte addresses on the plain register port)
    // -------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_COUNT_LOW = 12'h59C;
    localparam logic [11:0] OFS_COUNT_HIGH = 12'h59D;
    localparam logic [11:0] OFS_CONTROL_ZERO = 12'h59E;
    localparam logic [11:0] OFS_CONTROL_ONE = 12'h59F;

    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int CZ_ENABLE_BIT = 7;
    localparam int CZ_OUT_BIT = 5;
    localparam int CZ_WIDE_BIT = 4;
    localparam int CZ_POST_LSB = 0;
    localparam int CO_CS_LSB = 5;
    localparam int CO_ASYNC_BIT = 4;
    localparam int CO_PRE_LSB = 0;

    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic [7:0] RST_COUNT_LOW = 8'h00;
    localparam logic [7:0] RST_COUNT_HIGH = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // -------------------------------------------------------------
    // clock source codes
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        CS_PIN = 3'h0,
        CS_PIN_INV = 3'h1,
        CS_INSTR = 3'h2,
        CS_HIGH_OSC = 3'h3,
        CS_LOW_OSC = 3'h4,
        CS_MEDIUM_OSC = 3'h5,
        CS_SECONDARY = 3'h6,
        CS_LOGIC_CELL = 3'h7
    } tmo_source_t;

    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int INSTR_DIV = 4;
    localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);
    localparam int PRE_W = 15;
endpackage

// ===== hdl/tmo_source_select.sv
`timescale 1ns/1ps
module tmo_source_select
    import tmo_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [2:0] sourceSel,
    input wire logic instrTick,
    input wire logic inputPin,
    input wire logic highOsc,
    input wire logic lowOsc,
    input wire logic mediumOsc,
    input wire logic secondaryOsc,
    input wire logic logicCellOne,
    output logic sourceEdge
);
    logic level;
    logic prevLevel;

    // -------------------------------------------------------------
    // source mux
    // -------------------------------------------------------------
    always_comb begin
        case (tmo_source_t'(sourceSel))
            CS_PIN: level = inputPin;
            CS_PIN_INV: level = ~inputPin;
            CS_HIGH_OSC: level = highOsc;
            CS_LOW_OSC: level = lowOsc;
            CS_MEDIUM_OSC: level = mediumOsc;
            CS_SECONDARY: level = secondaryOsc;
            CS_LOGIC_CELL: level = logicCellOne;
            default: level = 1'b0;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prevLevel <= 1'b0;
        end else begin
            prevLevel <= level;
        end
    end

    // instruction clock is already a one-cycle enable, so it is its own edge
    assign sourceEdge = (tmo_source_t'(sourceSel) == CS_INSTR) ? instrTick
                                                               : (level & ~prevLevel);
endmodule

// ===== hdl/tmo_timer0.sv
`timescale 1ns/1ps
module tmo_timer0
    import tmo_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    output logic [7:0] rdData,
    input wire logic sleepMode,
    input wire logic inputPin,
    input wire logic highOsc,
    input wire logic lowOsc,
    input wire logic mediumOsc,
    input wire logic secondaryOsc,
    input wire logic logicCellOne,
    input wire logic timerInterruptEnable,
    input wire logic flagClear,
    output logic timerInterruptFlag,
    output logic interruptRequest,
    output logic wakeRequest,
    output logic timerOutputSignal
);
    // -------------------------------------------------------------
    // registers and state
    // -------------------------------------------------------------
    logic [7:0] countLow;
    logic [7:0] countHighOrPeriod;
    logic [7:0] counterHigh;
    logic [7:0] periodBuf;
    logic moduleEnable;
    logic wideCountSelect;
    logic [3:0] postscalerSelect;
    logic [2:0] clockSourceSelect;
    logic asyncInputSelect;
    logic [3:0] prescalerSelect;
    logic [PRE_W-1:0] preCount;
    logic [3:0] postCount;
    logic [1:0] instrDiv;
    logic pendingTick;

    logic instrTick;
    logic sourceEdge;
    logic edgeGuard;
    logic sourceEdgeOk;
    logic running;
    logic [PRE_W-1:0] preMask;
    logic preTick;
    logic countTick;
    logic timerEvent;
    logic matchHit;
    logic rollover;
    logic postHit;
    logic wrLow;
    logic wrHigh;
    logic wrCtl;
    logic rdLow;

    // -------------------------------------------------------------
    // register decode
    // -------------------------------------------------------------
    assign wrLow = wrEn && (addr == OFS_COUNT_LOW);
    assign wrHigh = wrEn && (addr == OFS_COUNT_HIGH);
    assign wrCtl = wrEn && ((addr == OFS_CONTROL_ZERO) || (addr == OFS_CONTROL_ONE));
    assign rdLow = rdEn && (addr == OFS_COUNT_LOW);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            moduleEnable <= 1'b0;
            wideCountSelect <= 1'b0;
            postscalerSelect <= RST_CONTROL[3:0];
        end else if (wrEn && addr == OFS_CONTROL_ZERO) begin
            moduleEnable <= wrData[CZ_ENABLE_BIT];
            wideCountSelect <= wrData[CZ_WIDE_BIT];
            postscalerSelect <= wrData[CZ_POST_LSB +: 4];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clockSourceSelect <= RST_CONTROL[2:0];
            asyncInputSelect <= 1'b0;
            prescalerSelect <= RST_CONTROL[3:0];
        end else if (wrEn && addr == OFS_CONTROL_ONE) begin
            clockSourceSelect <= wrData[CO_CS_LSB +: 3];
            asyncInputSelect <= wrData[CO_ASYNC_BIT];
            prescalerSelect <= wrData[CO_PRE_LSB +: 4];
        end
    end

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdData <= READ_UNMAPPED;
        end else if (rdEn) begin
            case (addr)
                OFS_COUNT_LOW: rdData <= countLow;
                OFS_COUNT_HIGH: rdData <= countHighOrPeriod;
                OFS_CONTROL_ZERO: rdData <= {moduleEnable, 1'b0, timerOutputSignal,
                                             wideCountSelect, postscalerSelect};
                OFS_CONTROL_ONE: rdData <= {clockSourceSelect, asyncInputSelect,
                                            prescalerSelect};
                default: rdData <= READ_UNMAPPED;
            endcase
        end else begin
            rdData <= READ_UNMAPPED;
        end
    end

    // -------------------------------------------------------------
    // clock source, instruction clock and prescaler
    // -------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            instrDiv <= 2'h0;
        end else begin
            instrDiv <= instrDiv + 2'h1;
        end
    end
    assign instrTick = (instrDiv == INSTR_LAST);

    tmo_source_select u_source (
        .clock(clock),
        .rst(rst),
        .sourceSel(clockSourceSelect),
        .instrTick(instrTick),
        .inputPin(inputPin),
        .highOsc(highOsc),
        .lowOsc(lowOsc),
        .mediumOsc(mediumOsc),
        .secondaryOsc(secondaryOsc),
        .logicCellOne(logicCellOne),
        .sourceEdge(sourceEdge)
    );

    // a source switch compares the new level with the old one; one lost edge
    // after a control write is cheaper than a spurious count
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            edgeGuard <= 1'b1;
        end else begin
            edgeGuard <= wrCtl;
        end
    end
    assign sourceEdgeOk = sourceEdge && !edgeGuard;

    // the system clock is gone in sleep, so only asynchronous mode keeps going
    assign running = moduleEnable && !(sleepMode && !asyncInputSelect);

    // mask bit i joins the compare once the ratio needs that stage
    for (genvar i = 0; i < PRE_W; i++) begin : g_pre_mask
        assign preMask[i] = (prescalerSelect > 4'(i));
    end
    assign preTick = running && sourceEdgeOk && ((preCount & preMask) == preMask);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            preCount <= '0;
        end else if (wrLow || wrCtl) begin
            preCount <= '0;
        end else if (running && sourceEdgeOk) begin
            preCount <= preCount + PRE_W'(1);
        end
    end

    // synchronous mode: a prescaled edge waits for the next instruction tick
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pendingTick <= 1'b0;
        end else if (wrLow || wrCtl || !running || asyncInputSelect) begin
            pendingTick <= 1'b0;
        end else if (instrTick) begin
            pendingTick <= 1'b0;
        end else if (preTick) begin
            pendingTick <= 1'b1;
        end
    end

    always_comb begin
        if (asyncInputSelect) begin
            countTick = preTick;
        end else begin
            countTick = running && instrTick && (pendingTick || preTick);
        end
    end

    // -------------------------------------------------------------
    // counter
    // -------------------------------------------------------------
    assign matchHit = !wideCountSelect && (countLow == periodBuf);
    assign rollover = wideCountSelect && (countLow == 8'hFF) && (counterHigh == 8'hFF);
    assign timerEvent = countTick && !wrLow && (matchHit || rollover);

    // a low-byte write wins over a count that falls in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            countLow <= RST_COUNT_LOW;
        end else if (wrLow) begin
            countLow <= wrData;
        end else if (countTick) begin
            if (matchHit) begin
                countLow <= 8'h00;
            end else begin
                countLow <= countLow + 8'h01;
            end
        end
    end

    // the high byte counts on a carry out of the low byte in wide mode and loads the high register on a low-byte write
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            counterHigh <= RST_COUNT_HIGH;
        end else if (wrLow) begin
            counterHigh <= countHighOrPeriod;
        end else if (countTick && wideCountSelect && countLow == 8'hFF) begin
            counterHigh <= counterHigh + 8'h01;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            countHighOrPeriod <= RST_COUNT_HIGH;
        end else if (wrHigh) begin
            countHighOrPeriod <= wrData;
        end else if (rdLow && wideCountSelect) begin
            countHighOrPeriod <= counterHigh;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            periodBuf <= RST_COUNT_HIGH;
        end else if (countTick && matchHit && !wrLow) begin
            periodBuf <= countHighOrPeriod;
        end
    end

    // -------------------------------------------------------------
    // postscaler, output and flag
    // -------------------------------------------------------------
    // low-byte and control writes clear the count, so a new ratio never meets a stale partial count
    assign postHit = timerEvent && (postCount == postscalerSelect);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            postCount <= 4'h0;
        end else if (wrLow || wrCtl) begin
            postCount <= 4'h0;
        end else if (postHit) begin
            postCount <= 4'h0;
        end else if (timerEvent) begin
            postCount <= postCount + 4'h1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            timerOutputSignal <= 1'b0;
        end else if (postHit) begin
            timerOutputSignal <= ~timerOutputSignal;
        end
    end

    // a toggle in the clearing cycle wins, so no event is lost
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            timerInterruptFlag <= 1'b0;
        end else if (postHit) begin
            timerInterruptFlag <= 1'b1;
        end else if (flagClear) begin
            timerInterruptFlag <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // interrupt and wake requests
    // -------------------------------------------------------------
    assign interruptRequest = timerInterruptFlag && timerInterruptEnable;
    // only asynchronous counting can raise an event without the system clock
    assign wakeRequest = interruptRequest && sleepMode && asyncInputSelect;
endmodule

// ===== testbench/tmo_timer0_assertions.sv
`timescale 1ns/1ps
module tmo_timer0_assertions
    import tmo_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    input wire logic [7:0] rdData,
    input wire logic sleepMode,
    input wire logic inputPin,
    input wire logic highOsc,
    input wire logic lowOsc,
    input wire logic mediumOsc,
    input wire logic secondaryOsc,
    input wire logic logicCellOne,
    input wire logic timerInterruptEnable,
    input wire logic flagClear,
    input wire logic timerInterruptFlag,
    input wire logic interruptRequest,
    input wire logic wakeRequest,
    input wire logic timerOutputSignal
);
    // ---------------------------------------------------------
    // port relations
    // ---------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_req_from_flag: assert property (interruptRequest ==
        (timerInterruptFlag && timerInterruptEnable))
        else $error("request does not follow flag and enable");
    a_wake_in_sleep: assert property (wakeRequest |-> sleepMode && interruptRequest)
        else $error("wake request outside sleep or without request");
    a_quiet_read_bus: assert property (!$past(rdEn) |-> rdData == 8'h00)
        else $error("read data not idle without read");
    a_flag_on_toggle: assert property ($changed(timerOutputSignal) |-> timerInterruptFlag)
        else $error("output toggled without flag");
    a_flag_stays_set: assert property (timerInterruptFlag && !flagClear
        |=> timerInterruptFlag)
        else $error("flag dropped without clear");
    a_flag_needs_toggle: assert property ($rose(timerInterruptFlag)
        |-> $changed(timerOutputSignal))
        else $error("flag rose without output toggle");
    a_out_readback: assert property (rdEn && addr == OFS_CONTROL_ZERO
        |=> rdData[CZ_OUT_BIT] == $past(timerOutputSignal))
        else $error("output level bit differs from output");
    a_spare_bit_low: assert property (rdEn && addr == OFS_CONTROL_ZERO |=> !rdData[6])
        else $error("unused control bit reads high");
    cover property ($changed(timerOutputSignal));
    cover property ($rose(wakeRequest));
    cover property (rdEn && addr == OFS_CONTROL_ZERO);
endmodule

// ===== testbench/tmo_far_side.sv
`timescale 1ns/1ps
// ---------------------------------------------------------
// free-running counting sources, all synchronous to clock
// ---------------------------------------------------------
module tmo_far_side (
    input wire logic clock,
    input wire logic rst,
    output logic inputPin,
    output logic highOsc,
    output logic lowOsc,
    output logic mediumOsc,
    output logic secondaryOsc,
    output logic logicCellOne
);
    logic [5:0] ticks;
    logic [3:0] pinCount;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ticks <= 6'h00;
        end else begin
            ticks <= ticks + 6'h01;
        end
    end
    // pin period 12 is not a power of two, so it differs from every oscillator
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pinCount <= 4'h0;
        end else begin
            pinCount <= (pinCount == 4'hB) ? 4'h0 : pinCount + 4'h1;
        end
    end
    // each source has its own rising-edge period: 2, 8, 16, 32, 64 clocks
    assign highOsc = ticks[0];
    assign mediumOsc = ticks[2];
    assign logicCellOne = ticks[3];
    assign lowOsc = ticks[4];
    assign secondaryOsc = ticks[5];
    assign inputPin = (pinCount < 4'h6);
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb
    import tmo_pkg::*;
;
    logic clock, rst, wrEn, rdEn, sleepMode, timerInterruptEnable, flagClear;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wrData;
    wire logic [7:0] rdData;
    wire logic inputPin, highOsc, lowOsc, mediumOsc, secondaryOsc, logicCellOne;
    wire logic timerInterruptFlag, interruptRequest, wakeRequest, timerOutputSignal;
    int failCount, checksDone, n, toggles;
    int srcPer[8] = '{12, 12, 4, 2, 32, 8, 64, 16};
    logic [7:0] tHigh[7] = '{8'h03, 8'h00, 8'h00, 8'h02, 8'hFF, 8'h00, 8'h00};
    logic [7:0] tC1[7] = '{8'h50, 8'h50, 8'h53, 8'h51, 8'h50, 8'h60, 8'h40};
    logic [7:0] tC0[7] = '{8'h80, 8'h8F, 8'h80, 8'h81, 8'h80, 8'h80, 8'h80};
    int tPer[7] = '{16, 64, 32, 48, 1024, 4, 4};
    tmo_timer0 dut (.clock(clock), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
        .rdEn(rdEn), .rdData(rdData), .sleepMode(sleepMode), .inputPin(inputPin),
        .highOsc(highOsc), .lowOsc(lowOsc), .mediumOsc(mediumOsc), .secondaryOsc(secondaryOsc),
        .logicCellOne(logicCellOne), .timerInterruptEnable(timerInterruptEnable),
        .flagClear(flagClear), .timerInterruptFlag(timerInterruptFlag),
        .interruptRequest(interruptRequest), .wakeRequest(wakeRequest),
        .timerOutputSignal(timerOutputSignal));
    tmo_far_side far (.clock(clock), .rst(rst), .inputPin(inputPin), .highOsc(highOsc),
        .lowOsc(lowOsc), .mediumOsc(mediumOsc), .secondaryOsc(secondaryOsc),
        .logicCellOne(logicCellOne));
    always @(timerOutputSignal) toggles++;
    // ---------------------------------------------------------
    // bus and compare tasks
    // ---------------------------------------------------------
    task automatic fail_msg(input string m);
        failCount++;
        $display("unexpected t=%0t %s", $time, m);
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        checksDone++;
        if (got !== exp) fail_msg($sformatf("byte %h want %h", got, exp));
    endtask
    task automatic check_int(input int got, input int exp);
        checksDone++;
        if (got != exp) fail_msg($sformatf("count %0d want %0d", got, exp));
    endtask
    task automatic check_bit(input logic got, input logic exp);
        checksDone++;
        if (got !== exp) fail_msg($sformatf("bit %b want %b", got, exp));
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge clock);
        wrEn <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clock);
        rdEn <= 1'b0;
        @(negedge clock);
        check_byte(rdData, exp);
    endtask
    task automatic cfg(input logic [7:0] h, input logic [7:0] c1, input logic [7:0] c0);
        wr(OFS_COUNT_HIGH, h);
        wr(OFS_CONTROL_ONE, c1);
        wr(OFS_CONTROL_ZERO, c0);
        wr(OFS_COUNT_LOW, 8'h00);
    endtask
    // counts falling edges until the output changes, or lim runs out
    task automatic edge_wait(input int lim, output int cnt);
        logic prev;
        cnt = 0;
        prev = timerOutputSignal;
        while (timerOutputSignal === prev && cnt < lim) begin
            @(negedge clock);
            cnt++;
        end
    endtask
    // first gaps may still use the old period buffer, so the third is judged
    task automatic measure(input int exp);
        int m;
        edge_wait(4000, m);
        edge_wait(4000, m);
        edge_wait(4000, m);
        check_int(m, exp);
    endtask
    task automatic clear_flag();
        @(posedge clock);
        flagClear <= 1'b1;
        @(posedge clock);
        flagClear <= 1'b0;
    endtask
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", failCount, checksDone);
        if (failCount == 0 && checksDone > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ---------------------------------------------------------
    // stimulus
    // ---------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        #200000;
        fail_msg("watchdog expired");
        conclude();
    end
    initial begin
        {rst, wrEn, rdEn, sleepMode, timerInterruptEnable, flagClear} = 6'h20;
        addr = 12'h000;
        wrData = 8'h00;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) rd(OFS_COUNT_LOW + 12'(i), 8'h00);
        rd(12'h5A0, READ_UNMAPPED);
        wr(OFS_CONTROL_ZERO, 8'h60);
        rd(OFS_CONTROL_ZERO, 8'h00);
        cfg(8'hFF, 8'h50, 8'h10);
        wr(OFS_COUNT_LOW, 8'hFE);
        wr(OFS_COUNT_HIGH, 8'h12);
        rd(OFS_COUNT_LOW, 8'hFE);
        rd(OFS_COUNT_HIGH, 8'hFF);
        wr(OFS_CONTROL_ZERO, 8'h90);
        edge_wait(40, n);
        check_bit(n < 40, 1'b1);
        for (int s = 0; s < 8; s++) begin
            cfg(8'h00, {3'(s), 5'h10}, 8'h80);
            measure(srcPer[s]);
        end
        for (int i = 0; i < 7; i++) begin
            cfg(tHigh[i], tC1[i], tC0[i]);
            measure(tPer[i]);
        end
        for (int k = 0; k < 2; k++) begin
            cfg(8'h00, (k == 0) ? 8'h53 : 8'h50, (k == 0) ? 8'h80 : 8'h8F);
            n = toggles;
            repeat (40) begin
                wr(OFS_COUNT_LOW, 8'h00);
                @(posedge clock);
            end
            check_int(toggles - n, 0);
        end
        cfg(8'h00, 8'h50, 8'h80);
        timerInterruptEnable <= 1'b1;
        clear_flag();
        edge_wait(100, n);
        check_bit(timerInterruptFlag, 1'b1);
        check_bit(interruptRequest, 1'b1);
        check_bit(wakeRequest, 1'b0);
        @(posedge clock);
        sleepMode <= 1'b1;
        clear_flag();
        edge_wait(100, n);
        check_bit(n < 100, 1'b1);
        check_bit(wakeRequest, 1'b1);
        wr(OFS_CONTROL_ONE, 8'h40);
        @(negedge clock);
        edge_wait(200, n);
        check_int(n, 200);
        wr(OFS_CONTROL_ZERO, 8'h00);
        sleepMode <= 1'b0;
        clear_flag();
        edge_wait(200, n);
        check_int(n, 200);
        check_bit(interruptRequest, 1'b0);
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rd(OFS_CONTROL_ZERO, 8'h00);
        rd(OFS_CONTROL_ONE, 8'h00);
        conclude();
    end
endmodule
bind tmo_timer0 tmo_timer0_assertions chk (.clock(clock), .rst(rst), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .sleepMode(sleepMode),
    .inputPin(inputPin), .highOsc(highOsc), .lowOsc(lowOsc), .mediumOsc(mediumOsc),
    .secondaryOsc(secondaryOsc), .logicCellOne(logicCellOne),
    .timerInterruptEnable(timerInterruptEnable), .flagClear(flagClear),
    .timerInterruptFlag(timerInterruptFlag), .interruptRequest(interruptRequest),
    .wakeRequest(wakeRequest), .timerOutputSignal(timerOutputSignal));
